// ### core/pdt_pkg.sv
// What this block does
// - Two 8-bit down counters, separate or chained.
// - Chain select 0 gives two independent timers.
// - Load strobe copies reload value into counter.
// - Run bit gates counting (only timer 0's when chained); value held while stopped.
// - Low byte read holds high byte; low first.
// - Underflow reloads counter and counting continues.
// - Underflow drives flag, toggle and serial clock.
// - Serial clock comes from timer 1 underflows.
// - Timer 0 mode bit: 0 timer, 1 event.
// - Separate timer 1 counts only its prescaler output.
// - Event mode clocks timer 0 from pin.
// - Polarity 0 counts falling, 1 rising edges.
// - Filter select 1 inserts noise rejector.
// - Rejector accepts change at second 2048 Hz fall.
// - Each timer has its own independent prescaler.
// - Source select 0 low-speed, 1 high-speed oscillator.
// - Ratio 00/01/10/11 divides by 1/4/32/256.
// - Prescaler runs only while run bit is 1.
// - Chained mode: timer 0 low, timer 1 high byte.
// - Underflow sets flag always; request only unmasked.
// - Toggle halves underflows of selected timer.
package pdt_pkg;

	// Data width of one timer channel
	localparam int          CNT_W          = 8;
	typedef logic [CNT_W-1:0] pdt_byte_t;

	// Reset value and fixed counter values
	localparam pdt_byte_t   CNT_RST        = 8'h00;
	localparam pdt_byte_t   CNT_ZERO       = 8'h00;
	localparam pdt_byte_t   CNT_ONE        = 8'h01;
	localparam pdt_byte_t   CNT_FULL       = 8'hff;

	// Prescaler ratio codes and the divider masks they select
	localparam logic [1:0]  RATIO_DIV1     = 2'h0;
	localparam logic [1:0]  RATIO_DIV4     = 2'h1;
	localparam logic [1:0]  RATIO_DIV32    = 2'h2;
	localparam logic [1:0]  RATIO_DIV256   = 2'h3;
	localparam pdt_byte_t   MASK_DIV1      = 8'h00;
	localparam pdt_byte_t   MASK_DIV4      = 8'h03;
	localparam pdt_byte_t   MASK_DIV32     = 8'h1f;
	localparam pdt_byte_t   MASK_DIV256    = 8'hff;

	// Noise rejector: filter clock falls needed to accept a level
	localparam logic [1:0]  NF_ACCEPT_FALLS = 2'h2;
	localparam logic [1:0]  NF_CNT_RST      = 2'h0;

endpackage

// ### core/pdt_prescaler.sv
module pdt_prescaler
	import pdt_pkg::*;
(
	// Clock and reset
	input  logic        mclk,
	input  logic        rst,
	// Control
	input  logic        run,
	input  logic        src_tick,
	input  logic [1:0]  ratio,
	// Divided count clock
	output logic        cnt_tick
);

	pdt_byte_t cnt_r;
	pdt_byte_t mask;

	// Divider mask from ratio code
	always_comb begin
		case (ratio)
			RATIO_DIV1:   mask = MASK_DIV1;
			RATIO_DIV4:   mask = MASK_DIV4;
			RATIO_DIV32:  mask = MASK_DIV32;
			RATIO_DIV256: mask = MASK_DIV256;
			default:      mask = MASK_DIV1;
		endcase
	end

	// Free counter of source ticks, cleared while stopped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r    <= CNT_RST;
			cnt_tick <= 1'b0;
		end else if (!run) begin
			cnt_r    <= CNT_RST;
			cnt_tick <= 1'b0;
		end else begin
			cnt_tick <= src_tick && ((cnt_r & mask) == mask);
			if (src_tick)
				cnt_r <= cnt_r + CNT_ONE;
		end
	end

	// No count clock leaves a stopped prescaler
	presc_stop_a: assert property (@(posedge mclk) disable iff (rst)
		!run |=> (cnt_r == CNT_RST) && !cnt_tick)
		else $error("prescaler active while stopped");

endmodule

// ### core/pdt_noise_filter.sv
module pdt_noise_filter
	import pdt_pkg::*;
(
	// Clock and reset
	input  logic        mclk,
	input  logic        rst,
	// Raw level and falling edges of the filter clock
	input  logic        level_in,
	input  logic        filt_fall_tick,
	// Accepted level
	output logic        level_out
);

	logic [1:0] falls_r;

	// Accept a new level only after two filter clock falls
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			falls_r   <= NF_CNT_RST;
			level_out <= 1'b0;
		end else if (level_in == level_out) begin
			falls_r <= NF_CNT_RST;          // Glitch gone: restart
		end else if (filt_fall_tick) begin
			if (falls_r + 2'h1 == NF_ACCEPT_FALLS) begin
				level_out <= level_in;
				falls_r   <= NF_CNT_RST;
			end else begin
				falls_r <= falls_r + 2'h1;
			end
		end
	end

	// Output changes only on a filter clock fall
	nf_edge_a: assert property (@(posedge mclk) disable iff (rst)
		(level_out != $past(level_out)) |-> $past(filt_fall_tick) && $past(falls_r) == 2'h1)
		else $error("noise rejector accepted level early");

endmodule

// ### core/pdt_top.sv
module pdt_top
	import pdt_pkg::*;
(
	// Clock and reset
	input  logic        mclk,
	input  logic        rst,
	// Oscillator ticks, one-cycle enables
	input  logic        low_speed_osc,
	input  logic        high_speed_osc,
	input  logic        filt_fall_tick,
	// Mode control
	input  logic        chain_select,
	input  logic        event_mode_select,
	input  logic        event_edge_polarity,
	input  logic        noise_filter_select,
	input  logic        toggle_channel_select,
	// Timer 0 control
	input  pdt_pkg::pdt_byte_t reload_value_t0,
	input  logic        counter_load_strobe_t0,
	input  logic        run_t0,
	input  logic        source_select_t0,
	input  logic [1:0]  prescale_ratio_t0,
	// Timer 1 control
	input  pdt_pkg::pdt_byte_t reload_value_t1,
	input  logic        counter_load_strobe_t1,
	input  logic        run_t1,
	input  logic        source_select_t1,
	input  logic [1:0]  prescale_ratio_t1,
	// Readback strobes
	input  logic        read_low_strobe,
	input  logic        read_high_strobe,
	// Interrupt control
	input  logic        irq_enable_t0,
	input  logic        irq_enable_t1,
	input  logic        flag_clear_t0,
	input  logic        flag_clear_t1,
	// External event pin
	input  logic        event_input_pin,
	// Readback data
	output pdt_pkg::pdt_byte_t count_readback_t0,
	output pdt_pkg::pdt_byte_t count_readback_t1,
	// Events and interrupts
	output logic        underflow_pulse_t0,
	output logic        underflow_pulse_t1,
	output logic        underflow_flag_t0,
	output logic        underflow_flag_t1,
	output logic        irq_t0,
	output logic        irq_t1,
	// Derived clocks
	output logic        toggle_out,
	output logic        serial_clk
);

	pdt_byte_t cnt0_r;
	pdt_byte_t cnt1_r;
	pdt_byte_t hold_r;
	logic      hold_act_r;
	logic      ev_prev_r;
	logic      presc0_tick;
	logic      presc1_tick;
	logic      ev_filt;
	logic      ev_level;
	logic      ev_edge;
	logic      tick0;
	logic      tick1;
	logic      borrow0;
	logic      step1;
	logic      uf0;
	logic      uf1;
	logic      run0_eff;
	logic      run1_eff;
	logic      flag0_nxt;
	logic      flag1_nxt;

	// Timer 0 prescaler runs only in timer mode, timer 1 only in separate mode; each only while its timer runs
	assign run0_eff = run_t0 && !event_mode_select;
	assign run1_eff = run_t1 && !chain_select;

	// Timer 0 prescaler with its own source choice
	pdt_prescaler u_presc0 (
		.mclk     (mclk),
		.rst      (rst),
		.run      (run0_eff),
		.src_tick (source_select_t0 ? high_speed_osc : low_speed_osc),
		.ratio    (prescale_ratio_t0),
		.cnt_tick (presc0_tick)
	);

	// Timer 1 prescaler, independent of timer 0
	pdt_prescaler u_presc1 (
		.mclk     (mclk),
		.rst      (rst),
		.run      (run1_eff),
		.src_tick (source_select_t1 ? high_speed_osc : low_speed_osc),
		.ratio    (prescale_ratio_t1),
		.cnt_tick (presc1_tick)
	);

	// Chatter rejector on the event pin
	pdt_noise_filter u_filt (
		.mclk           (mclk),
		.rst            (rst),
		.level_in       (event_input_pin),
		.filt_fall_tick (filt_fall_tick),
		.level_out      (ev_filt)
	);

	// Event level, filtered or raw
	assign ev_level = noise_filter_select ? ev_filt : event_input_pin;

	// Previous event level for edge detection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ev_prev_r <= 1'b0;
		else
			ev_prev_r <= ev_level;
	end

	// Rising or falling edge chosen by polarity
	assign ev_edge = event_edge_polarity ? (ev_level && !ev_prev_r)
		: (!ev_level && ev_prev_r);

	// Count clocks; timer 1 never sees the event pin
	assign tick0 = run_t0 && (event_mode_select ? ev_edge : presc0_tick);
	assign tick1 = run_t1 && !chain_select && presc1_tick;

	// Low byte wraps; in chained mode the high byte takes the borrow
	assign borrow0 = tick0 && (cnt0_r == CNT_ZERO) && !counter_load_strobe_t0;
	assign step1   = chain_select ? borrow0 : tick1;

	// Underflow events; a load in the same cycle takes precedence
	assign uf0 = borrow0 && !chain_select && !counter_load_strobe_t0;
	assign uf1 = step1 && (cnt1_r == CNT_ZERO) && !counter_load_strobe_t1
		&& !(chain_select && counter_load_strobe_t0);

	// Timer 0 counter: load, reload or go to all ones on wrap, or decrement
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt0_r <= CNT_RST;
		end else if (counter_load_strobe_t0) begin
			cnt0_r <= reload_value_t0;
		end else if (borrow0) begin
			if (chain_select && cnt1_r != CNT_ZERO)
				cnt0_r <= CNT_FULL;
			else
				cnt0_r <= reload_value_t0;
		end else if (tick0) begin
			cnt0_r <= cnt0_r - CNT_ONE;
		end
	end

	// Timer 1 counter: load, reload on underflow, or decrement
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt1_r <= CNT_RST;
		end else if (counter_load_strobe_t1) begin
			cnt1_r <= reload_value_t1;
		end else if (step1 && cnt1_r == CNT_ZERO) begin
			cnt1_r <= reload_value_t1;
		end else if (step1) begin
			cnt1_r <= cnt1_r - CNT_ONE;
		end
	end

	// High byte hold taken when the low byte is read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_r     <= CNT_RST;
			hold_act_r <= 1'b0;
		end else if (read_low_strobe) begin
			hold_r     <= cnt1_r;
			hold_act_r <= 1'b1;
		end else if (read_high_strobe) begin
			hold_act_r <= 1'b0;
		end
	end

	// Readback buffers; high byte shows the held copy while held
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_readback_t0 <= CNT_RST;
			count_readback_t1 <= CNT_RST;
		end else begin
			count_readback_t0 <= cnt0_r;
			if (read_low_strobe)
				count_readback_t1 <= cnt1_r;
			else if (hold_act_r && !read_high_strobe)
				count_readback_t1 <= hold_r;
			else
				count_readback_t1 <= cnt1_r;
		end
	end

	// Sticky flags; a new underflow beats a clear in the same cycle
	assign flag0_nxt = uf0 || (underflow_flag_t0 && !flag_clear_t0);
	assign flag1_nxt = uf1 || (underflow_flag_t1 && !flag_clear_t1);

	// Flags, requests and underflow pulses
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			underflow_flag_t0  <= 1'b0;
			underflow_flag_t1  <= 1'b0;
			irq_t0             <= 1'b0;
			irq_t1             <= 1'b0;
			underflow_pulse_t0 <= 1'b0;
			underflow_pulse_t1 <= 1'b0;
		end else begin
			underflow_flag_t0  <= flag0_nxt;
			underflow_flag_t1  <= flag1_nxt;
			irq_t0             <= flag0_nxt && irq_enable_t0;
			irq_t1             <= flag1_nxt && irq_enable_t1;
			underflow_pulse_t0 <= uf0;
			underflow_pulse_t1 <= uf1;
		end
	end

	// Toggle output halves the selected timer's underflows
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			toggle_out <= 1'b0;
		else if (toggle_channel_select ? uf1 : uf0)
			toggle_out <= !toggle_out;
	end

	// Serial clock from halved timer 1 underflows
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			serial_clk <= 1'b0;
		else if (uf1)
			serial_clk <= !serial_clk;
	end

	// Load strobe presets the counter
	load_t0_a: assert property (@(posedge mclk) disable iff (rst)
		counter_load_strobe_t0 |=> cnt0_r == $past(reload_value_t0))
		else $error("timer 0 load missed");

	// Stopped timer keeps its value
	stop_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(!run_t1 && !counter_load_strobe_t1 && !chain_select) |=> cnt1_r == $past(cnt1_r))
		else $error("timer 1 moved while stopped");

	// Underflow reloads in separate mode
	reload_t0_a: assert property (@(posedge mclk) disable iff (rst)
		uf0 |=> cnt0_r == $past(reload_value_t0) && underflow_flag_t0)
		else $error("timer 0 reload or flag missing");

	// Decrement by one per count clock
	dec_t0_a: assert property (@(posedge mclk) disable iff (rst)
		(tick0 && cnt0_r != CNT_ZERO && !counter_load_strobe_t0)
		|=> cnt0_r == $past(cnt0_r) - CNT_ONE)
		else $error("timer 0 decrement wrong");

	// Masked flag never raises a request
	irq_mask_a: assert property (@(posedge mclk) disable iff (rst)
		!irq_enable_t1 |=> !irq_t1)
		else $error("masked request raised");

	// Toggle flips on each selected underflow
	toggle_flip_a: assert property (@(posedge mclk) disable iff (rst)
		(toggle_channel_select ? uf1 : uf0) |=> toggle_out != $past(toggle_out))
		else $error("toggle output missed underflow");

	// Serial clock flips only with timer 1 underflow
	serial_clk_a: assert property (@(posedge mclk) disable iff (rst)
		(serial_clk != $past(serial_clk)) |-> $past(uf1))
		else $error("serial clock changed without underflow");

	// Raw event mode counts only the chosen pin edge
	event_only_a: assert property (@(posedge mclk) disable iff (rst)
		(event_mode_select && tick0 && !noise_filter_select && !$past(noise_filter_select))
		|-> (event_edge_polarity ? $rose(event_input_pin) : $fell(event_input_pin)))
		else $error("event counter clocked without edge");

	// Held high byte stays put until released
	hold_high_a: assert property (@(posedge mclk) disable iff (rst)
		(hold_act_r && !read_low_strobe && !read_high_strobe)
		|=> count_readback_t1 == hold_r)
		else $error("high byte hold broken");

	// Chained high byte steps only on low byte borrow
	chain_step_a: assert property (@(posedge mclk) disable iff (rst)
		(chain_select && !counter_load_strobe_t1 && !borrow0) |=> cnt1_r == $past(cnt1_r))
		else $error("chained high byte moved without borrow");

	// Timer 1 reloads on its underflow
	reload_t1_a: assert property (@(posedge mclk) disable iff (rst)
		uf1 |=> cnt1_r == $past(reload_value_t1))
		else $error("timer 1 reload missing");

	// Underflow sets the flag even against a clear
	flag_set_a: assert property (@(posedge mclk) disable iff (rst)
		uf1 |=> underflow_flag_t1)
		else $error("timer 1 flag not set");

	// Request is the flag gated by its mask
	irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
		irq_t0 == (underflow_flag_t0 && $past(irq_enable_t0)))
		else $error("request does not follow flag and mask");

	// Chained low byte wraps to all ones and borrows from the high byte
	chain_borrow_a: assert property (@(posedge mclk) disable iff (rst)
		(chain_select && borrow0 && cnt1_r != CNT_ZERO && !counter_load_strobe_t1)
		|=> cnt0_r == CNT_FULL && cnt1_r == $past(cnt1_r) - CNT_ONE)
		else $error("chained borrow wrong");

	// Chained mode reports no timer 0 underflow
	chain_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		chain_select |=> !underflow_pulse_t0)
		else $error("timer 0 event in chained mode");

	// Timer 1 underflow pulses and clocks the serial path
	pulse_t1_a: assert property (@(posedge mclk) disable iff (rst)
		uf1 |=> underflow_pulse_t1 && serial_clk != $past(serial_clk))
		else $error("timer 1 underflow not reported");

	// Low byte buffer trails the counter by one cycle
	readback_t0_a: assert property (@(posedge mclk) disable iff (rst)
		1'h1 |=> count_readback_t0 == $past(cnt0_r))
		else $error("timer 0 readback stale");

	// Event mode silences the timer 0 prescaler
	presc_off_a: assert property (@(posedge mclk) disable iff (rst)
		event_mode_select |=> !presc0_tick)
		else $error("timer 0 prescaler active in event mode");

	// Separate timer 1 moves only on its own prescaler tick
	t1_presc_only_a: assert property (@(posedge mclk) disable iff (rst)
		(!chain_select && !presc1_tick && !counter_load_strobe_t1)
		|=> cnt1_r == $past(cnt1_r))
		else $error("timer 1 moved without prescaler tick");

	// Filtered event mode ignores changes the rejector has not accepted
	filt_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(event_mode_select && noise_filter_select && !counter_load_strobe_t0
		&& ev_filt == ev_prev_r) |=> cnt0_r == $past(cnt0_r))
		else $error("unfiltered edge reached timer 0");

	// Load strobe presets timer 1
	load_t1_a: assert property (@(posedge mclk) disable iff (rst)
		counter_load_strobe_t1 |=> cnt1_r == $past(reload_value_t1))
		else $error("timer 1 load missed");

	// Stopped timer 0 keeps its value
	run_hold_t0_a: assert property (@(posedge mclk) disable iff (rst)
		(!run_t0 && !counter_load_strobe_t0) |=> cnt0_r == $past(cnt0_r))
		else $error("timer 0 moved while stopped");

	// Toggle output holds between selected underflows
	toggle_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		!(toggle_channel_select ? uf1 : uf0) |=> toggle_out == $past(toggle_out))
		else $error("toggle output flipped without underflow");

endmodule

// ### sim/pdt_far_model.sv
module pdt_far_model (
	// Clock and reset
	input  logic       mclk,
	input  logic       rst,
	// Burst request from the bench
	input  logic       go,
	input  logic       hi,
	input  logic [8:0] nb,
	input  logic       ev_lvl,
	// Oscillator ticks and event pin
	output logic       low_speed_osc,
	output logic       high_speed_osc,
	output logic       filt_fall_tick,
	output logic       event_input_pin,
	output logic       busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] left_r;
	logic [2:0] div_r;
	logic       hi_r;

	assign busy = (left_r != 9'h000);

	// Oscillator bursts, one tick every other cycle, high only on request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			left_r <= 9'h000;
			hi_r <= 1'b0;
			low_speed_osc <= 1'b0;
			high_speed_osc <= 1'b0;
		end else begin
			low_speed_osc <= 1'b0;
			high_speed_osc <= 1'b0;
			if (go) begin
				left_r <= nb;
				hi_r <= hi;
			end else if (busy && !(low_speed_osc || high_speed_osc)) begin
				left_r <= left_r - 9'h001;
				low_speed_osc <= !hi_r;
				high_speed_osc <= hi_r;
			end
		end
	end

	// Filter clock falls every 8 cycles; pin follows the bench's held level
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_r <= 3'h0;
			filt_fall_tick <= 1'b0;
			event_input_pin <= 1'b0;
		end else begin
			div_r <= div_r + 3'h1;
			filt_fall_tick <= (div_r == 3'h7);
			event_input_pin <= ev_lvl;
		end
	end
endmodule

// ### sim/pdt_top_test.sv
module pdt_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pdt_pkg::*;
	logic mclk, rst, low_speed_osc, high_speed_osc, filt_fall_tick, event_input_pin;
	logic chain_select, event_mode_select, event_edge_polarity, noise_filter_select;
	logic toggle_channel_select, counter_load_strobe_t0, counter_load_strobe_t1;
	logic run_t0, run_t1, source_select_t0, source_select_t1;
	logic [1:0] prescale_ratio_t0, prescale_ratio_t1;
	pdt_byte_t reload_value_t0, reload_value_t1, count_readback_t0, count_readback_t1;
	logic read_low_strobe, read_high_strobe, irq_enable_t0, irq_enable_t1;
	logic flag_clear_t0, flag_clear_t1, underflow_pulse_t0, underflow_pulse_t1;
	logic underflow_flag_t0, underflow_flag_t1, irq_t0, irq_t1, toggle_out, serial_clk;
	logic go, hi, ev_lvl, busy;
	logic [8:0] nb;
	int fails, n_tests, n_uf0, n_uf1;

	pdt_top pdt_top_i (.mclk, .rst, .low_speed_osc, .high_speed_osc, .filt_fall_tick,
		.chain_select, .event_mode_select, .event_edge_polarity, .noise_filter_select,
		.toggle_channel_select, .reload_value_t0, .counter_load_strobe_t0, .run_t0,
		.source_select_t0, .prescale_ratio_t0, .reload_value_t1, .counter_load_strobe_t1,
		.run_t1, .source_select_t1, .prescale_ratio_t1, .read_low_strobe, .read_high_strobe,
		.irq_enable_t0, .irq_enable_t1, .flag_clear_t0, .flag_clear_t1, .event_input_pin,
		.count_readback_t0, .count_readback_t1, .underflow_pulse_t0, .underflow_pulse_t1,
		.underflow_flag_t0, .underflow_flag_t1, .irq_t0, .irq_t1, .toggle_out, .serial_clk);
	pdt_far_model pdt_far_model_i (.mclk, .rst, .go, .hi, .nb, .ev_lvl, .low_speed_osc,
		.high_speed_osc, .filt_fall_tick, .event_input_pin, .busy);

	// Clock at 200 MHz
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Step edges, then settle off the sampling edge
	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(string nm, pdt_byte_t exp, pdt_byte_t got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chb(string nm, logic exp, logic got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %b seen %b", nm, exp, got);
		end
	endtask
	// Exact number of oscillator ticks, then let the pipeline drain
	task automatic ticks(int n, logic h);
		go = 1'b1;
		nb = n[8:0];
		hi = h;
		cyc(1);
		go = 1'b0;
		cyc(1);
		for (int i = 0; i < 2000 && busy === 1'b1; i++) cyc(1);
		chb("busy", 1'b0, busy);
		cyc(5);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(2);
	endtask
	task automatic load(pdt_byte_t v0, pdt_byte_t v1);
		reload_value_t0 = v0;
		reload_value_t1 = v1;
		counter_load_strobe_t0 = 1'b1;
		counter_load_strobe_t1 = 1'b1;
		cyc(1);
		counter_load_strobe_t0 = 1'b0;
		counter_load_strobe_t1 = 1'b0;
		cyc(2);
	endtask
	// Event pin pulses, each level held w cycles
	task automatic evp(int n, int w);
		repeat (n) begin
			ev_lvl = ~ev_lvl;
			cyc(w);
			ev_lvl = ~ev_lvl;
			cyc(w);
		end
	endtask
	task automatic summarize;
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Count one-cycle underflow pulses so they are seen while they stand
	always @(posedge mclk) begin
		if (underflow_pulse_t0 === 1'b1)
			n_uf0++;
		if (underflow_pulse_t1 === 1'b1)
			n_uf1++;
	end

	// Watchdog well beyond the expected run length
	initial begin
		#100000;
		fails++;
		summarize();
	end

	// Test sequence
	initial begin
		{chain_select, event_mode_select, event_edge_polarity, noise_filter_select} = 4'h0;
		{toggle_channel_select, counter_load_strobe_t0, counter_load_strobe_t1} = 3'h0;
		{run_t0, run_t1, source_select_t0, source_select_t1, go, hi, ev_lvl} = 7'h00;
		{read_low_strobe, read_high_strobe, irq_enable_t0, irq_enable_t1} = 4'h0;
		{flag_clear_t0, flag_clear_t1, prescale_ratio_t0, prescale_ratio_t1} = 6'h00;
		{reload_value_t0, reload_value_t1, nb} = 25'h0;
		fails = 0;
		n_tests = 0;
		n_uf0 = 0;
		n_uf1 = 0;
		rst = 1'b1;
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		cyc(1);
		chk("readback_t0", 8'h00, count_readback_t0);
		chb("toggle_out", 1'b0, toggle_out);
		// Independent timer 0 on the low-speed source, ratio 1
		load(8'h05, 8'h00);
		run_t0 = 1'b1;
		ticks(3, 1'b0);
		chk("readback_t0", 8'h02, count_readback_t0);
		run_t0 = 1'b0;
		ticks(3, 1'b0);
		chk("readback_t0", 8'h02, count_readback_t0);
		run_t0 = 1'b1;
		ticks(3, 1'b0);
		chk("readback_t0", 8'h05, count_readback_t0);
		chb("flag_t0", 1'b1, underflow_flag_t0);
		chb("irq_t0", 1'b0, irq_t0);
		chb("toggle_out", 1'b1, toggle_out);
		chk("pulses_t0", 8'h01, n_uf0[7:0]);
		chk("readback_t1", 8'h00, count_readback_t1);
		ticks(4, 1'b1);
		chk("readback_t0", 8'h05, count_readback_t0);
		irq_enable_t0 = 1'b1;
		cyc(1);
		chb("irq_t0", 1'b1, irq_t0);
		pulse(flag_clear_t0);
		chb("flag_t0", 1'b0, underflow_flag_t0);
		run_t0 = 1'b0;
		// Timer 1 on the high-speed source through the 4, 32 and 256 dividers
		source_select_t1 = 1'b1;
		prescale_ratio_t1 = RATIO_DIV4;
		load(8'h05, 8'h0a);
		run_t1 = 1'b1;
		ticks(8, 1'b1);
		chk("readback_t1", 8'h08, count_readback_t1);
		ticks(8, 1'b0);
		chk("readback_t1", 8'h08, count_readback_t1);
		for (int r = 2; r < 4; r++) begin
			run_t1 = 1'b0;
			cyc(1);
			prescale_ratio_t1 = r[1:0];
			run_t1 = 1'b1;
			ticks((r == 2) ? 32 : 256, 1'b1);
			chk("readback_t1", 8'h09 - r[7:0], count_readback_t1);
		end
		// Timer 1 underflow feeds serial clock and selected toggle
		run_t1 = 1'b0;
		prescale_ratio_t1 = RATIO_DIV1;
		toggle_channel_select = 1'b1;
		load(8'h05, 8'h01);
		run_t1 = 1'b1;
		ticks(2, 1'b1);
		chb("serial_clk", 1'b1, serial_clk);
		chb("flag_t1", 1'b1, underflow_flag_t1);
		chb("irq_t1", 1'b0, irq_t1);
		chb("toggle_out", 1'b0, toggle_out);
		chk("pulses_t1", 8'h01, n_uf1[7:0]);
		chk("readback_t1", 8'h01, count_readback_t1);
		run_t1 = 1'b0;
		pulse(flag_clear_t1);
		chb("flag_t1", 1'b0, underflow_flag_t1);
		// Event counting on both edge polarities
		event_mode_select = 1'b1;
		load(8'h09, 8'h01);
		run_t0 = 1'b1;
		ticks(4, 1'b0);
		chk("readback_t0", 8'h09, count_readback_t0);
		evp(2, 4);
		chk("readback_t0", 8'h07, count_readback_t0);
		event_edge_polarity = 1'b1;
		evp(2, 4);
		chk("readback_t0", 8'h05, count_readback_t0);
		// Noise rejector drops a short glitch, keeps a long level
		noise_filter_select = 1'b1;
		evp(1, 3);
		cyc(20);
		chk("readback_t0", 8'h05, count_readback_t0);
		evp(1, 40);
		chk("readback_t0", 8'h04, count_readback_t0);
		{event_mode_select, noise_filter_select, run_t0} = 3'h0;
		// Chained 16-bit count with high byte hold
		chain_select = 1'b1;
		load(8'h00, 8'h01);
		run_t0 = 1'b1;
		pulse(read_low_strobe);
		ticks(1, 1'b0);
		chk("readback_t0", 8'hff, count_readback_t0);
		chk("readback_t1", 8'h01, count_readback_t1);
		pulse(read_high_strobe);
		chk("readback_t1", 8'h00, count_readback_t1);
		ticks(256, 1'b0);
		chk("readback_t1", 8'h01, count_readback_t1);
		chk("readback_t0", 8'h00, count_readback_t0);
		chb("flag_t1", 1'b1, underflow_flag_t1);
		chb("flag_t0", 1'b0, underflow_flag_t0);
		chk("pulses_t1", 8'h02, n_uf1[7:0]);
		chk("pulses_t0", 8'h01, n_uf0[7:0]);
		irq_enable_t1 = 1'b1;
		cyc(1);
		chb("irq_t1", 1'b1, irq_t1);
		summarize();
	end
endmodule
